/* File: hw/dxen_gate.sv */
// drive enable gate: hw enable, local switch and enable command, with apb registers
// Operation
// - motion only with enable, switch and command
// - wiring of common reference sets input polarity
// - software polarity setting, drive enable excluded
// - hardware enable state readable, never writable
// - local switch position readable, never writable
// - reset command or writing one enables
// - selected general input may supply command
// - combined mode enables on last rising input
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "dxen_defines.svh"
module dxen_gate (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_sys_rst,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // pins
   input  wire logic        i_hw_enable_pin,         // enable input energised
   input  wire logic        i_local_switch,          // switch 8 of the front panel block, on = 1
   input  wire logic        i_input_common_reference,// 1 = common reference at supply
   input  wire logic [7:0]  i_general_input,         // raw levels, general_input_first..last
   // gated results
   output logic             o_motion_permit,
   output logic [7:0]       o_general_input_active
);
   logic [10:0]             pins_s;        // synchronised pin levels
   logic                    hw_act;        // enable input, polarity never altered
   logic                    sw_act;        // local switch on
   logic                    ref_s;         // common reference at supply
   logic                    pol_low;       // general inputs active low
   logic [7:0]              din_act;       // general inputs after polarity
   logic                    cmd_reg;       // latched enable command
   logic                    cmd_ok;        // command condition satisfied
   logic                    both_act;      // switch and enable both active
   logic                    both_prev_reg; // for the combined mode edge
   dxen_pkg::dxen_ctrl_s    ctrl_reg;      // software settings
   logic                    acc;           // apb access completes this edge
   logic                    wr_ctrl;       // completing write to control
   logic                    hit_ctrl;
   logic                    hit_stat;

   // address decode, one call for every register of the map
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
      return (addr == ofs);
   endfunction

   // every pin crosses into the clock domain before use
   // latency: a pin change is seen two edges later and reaches the outputs one edge after that
   dxen_sync #(
      .WIDTH(11)
   ) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_async  ({i_input_common_reference, i_local_switch, i_hw_enable_pin, i_general_input}),
      .o_sync   (pins_s)
   );

   assign ref_s  = pins_s[10];
   assign sw_act = pins_s[9];
   assign hw_act = pins_s[8];   // drive enable is outside the polarity setting

   // polarity: software override if set, otherwise the wiring decides
   assign pol_low  = ctrl_reg.pol_ovr ? ctrl_reg.pol_low : ref_s;
   assign din_act  = pins_s[7:0] ^ {8{pol_low}};
   assign both_act = hw_act & sw_act;

   // command source: selected general input is a level, otherwise the latch
   assign cmd_ok = ctrl_reg.sel_en ? din_act[ctrl_reg.sel_idx] : cmd_reg;

   // apb decode; one wait state, completion when pready is seen high
   assign acc      = i_psel & i_penable & o_pready;
   assign hit_ctrl = reg_hit(i_paddr, `DXEN_OFS_CTRL);
   assign hit_stat = reg_hit(i_paddr, `DXEN_OFS_STATUS);
   assign wr_ctrl  = acc & i_pwrite & hit_ctrl;

   // ready rises for one cycle after the first access cycle
   // ready is cleared at the completing edge, so a back-to-back transfer never sees a stale one
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= i_psel & i_penable & ~o_pready;
      end
   end

   // read data and error are loaded together with ready
   // unmapped reads return zero so a stray address cannot leak the control word
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (i_psel & i_penable & ~o_pready) begin
         o_pslverr <= ~(hit_ctrl | hit_stat);  // unmapped address answers with an error
         o_prdata  <= 32'h0000_0000;
         if (!i_pwrite && hit_ctrl) begin
            o_prdata[`DXEN_CTRL_CMD_BIT]  <= cmd_reg;
            o_prdata[`DXEN_CTRL_COMB_BIT] <= ctrl_reg.comb_mode;
            o_prdata[`DXEN_CTRL_POVR_BIT] <= ctrl_reg.pol_ovr;
            o_prdata[`DXEN_CTRL_PLOW_BIT] <= ctrl_reg.pol_low;
            o_prdata[`DXEN_CTRL_IDX_MSB:`DXEN_CTRL_IDX_LSB] <= ctrl_reg.sel_idx;
            o_prdata[`DXEN_CTRL_SEL_BIT]  <= ctrl_reg.sel_en;
         end else if (!i_pwrite && hit_stat) begin
            // status is computed from live state only; writes here have no path
            o_prdata[0]    <= hw_act;
            o_prdata[1]    <= sw_act;
            o_prdata[2]    <= cmd_ok;
            o_prdata[3]    <= o_motion_permit;
            o_prdata[4]    <= pol_low;
            o_prdata[15:8] <= din_act;
         end
      end
   end

   // control settings
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_reg <= '0;
      end else if (wr_ctrl) begin
         ctrl_reg.comb_mode <= i_pwdata[`DXEN_CTRL_COMB_BIT];
         ctrl_reg.pol_ovr   <= i_pwdata[`DXEN_CTRL_POVR_BIT];
         ctrl_reg.pol_low   <= i_pwdata[`DXEN_CTRL_PLOW_BIT];
         ctrl_reg.sel_idx   <= i_pwdata[`DXEN_CTRL_IDX_MSB:`DXEN_CTRL_IDX_LSB];
         ctrl_reg.sel_en    <= i_pwdata[`DXEN_CTRL_SEL_BIT];
      end
   end

   // edge memory for combined mode
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         both_prev_reg <= 1'b0;
      end else begin
         both_prev_reg <= both_act;
      end
   end

   // command latch: sets win over the clear so a same-cycle request is kept
   // every control write rewrites the command bit, so turning the input source off
   // cannot bring back an old software command by surprise
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cmd_reg <= 1'b0;
      end else if (wr_ctrl && (i_pwdata[`DXEN_CTRL_CMD_BIT] || i_pwdata[`DXEN_CTRL_RST_BIT])) begin
         cmd_reg <= 1'b1;
      end else if (ctrl_reg.comb_mode && both_act && !both_prev_reg) begin
         cmd_reg <= 1'b1;                       // last input to rise enables
      end else if (wr_ctrl) begin
         cmd_reg <= 1'b0;                       // software wrote a zero
      end else if (o_motion_permit && !both_act) begin
         cmd_reg <= 1'b0;                       // a fresh command is needed afterwards
      end
   end

   // motion permission: all three conditions at once
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_motion_permit        <= 1'b0;
         o_general_input_active <= 8'h00;
      end else begin
         o_motion_permit        <= hw_act & sw_act & cmd_ok;
         o_general_input_active <= din_act;
      end
   end

   // all checks run in the one system clock domain and pause while reset is high
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   // enable conditions and their withdrawal
   a_permit_needs_all: assert property (o_motion_permit |-> $past(hw_act && sw_act && cmd_ok))
      else $error("motion permitted without all conditions");
   a_loss_withdraws: assert property ((!hw_act || !sw_act) |=> !o_motion_permit)
      else $error("permission kept after a condition was lost");
   a_drop_clears_cmd: assert property (o_motion_permit && !both_act && !wr_ctrl |=> !cmd_reg)
      else $error("command kept after a condition was lost");

   // general input polarity; the output is one edge behind the setting that made it
   a_wiring_polarity: assert property (
      !ctrl_reg.pol_ovr |=> o_general_input_active == ($past(pins_s[7:0]) ^ {8{$past(ref_s)}}))
      else $error("polarity does not follow wiring");
   a_sw_polarity: assert property (
      ctrl_reg.pol_ovr && $stable(ctrl_reg) |=>
         o_general_input_active == ($past(pins_s[7:0]) ^ {8{$past(ctrl_reg.pol_low)}}))
      else $error("software polarity not applied");

   // status reads follow live state, status writes touch nothing
   a_hw_status_read: assert property (
      i_psel && i_penable && !o_pready && !i_pwrite && hit_stat |=> o_prdata[0] == $past(hw_act))
      else $error("enable status read wrong");
   a_switch_status_read: assert property (
      i_psel && i_penable && !o_pready && !i_pwrite && hit_stat |=> o_prdata[1] == $past(sw_act))
      else $error("switch status read wrong");
   a_status_write_kept: assert property (acc && i_pwrite && hit_stat |=> $stable(ctrl_reg))
      else $error("status write changed the settings");

   // command sources
   a_write_one_cmd: assert property (wr_ctrl && i_pwdata[`DXEN_CTRL_CMD_BIT] |=> cmd_reg)
      else $error("write of one did not set command");
   a_reset_cmd: assert property (wr_ctrl && i_pwdata[`DXEN_CTRL_RST_BIT] |=> cmd_reg)
      else $error("reset command did not set command");
   a_write_zero_cmd: assert property (
      wr_ctrl && !i_pwdata[`DXEN_CTRL_CMD_BIT] && !i_pwdata[`DXEN_CTRL_RST_BIT]
         && !(ctrl_reg.comb_mode && both_act && !both_prev_reg) |=> !cmd_reg)
      else $error("write of zero did not clear command");
   a_input_source: assert property (
      ctrl_reg.sel_en && hw_act && sw_act |=> o_motion_permit == $past(din_act[ctrl_reg.sel_idx]))
      else $error("selected input not the command source");
   a_combined_edge: assert property (ctrl_reg.comb_mode && both_act && !both_prev_reg |=> cmd_reg)
      else $error("combined mode missed the enabling edge");

   // main scenarios worth seeing in any run
   c_permit: cover property (!o_motion_permit ##1 o_motion_permit);
   c_combined: cover property (ctrl_reg.comb_mode && both_act && !both_prev_reg);
   c_input_cmd: cover property (ctrl_reg.sel_en && o_motion_permit);
   c_bad_addr: cover property (o_pready && o_pslverr);
   c_drop: cover property (o_motion_permit ##1 !o_motion_permit);
endmodule

/* File: hw/dxen_defines.svh */
// register offsets, field positions and synchroniser depth of the drive enable gate
`ifndef DXEN_DEFINES_SVH
`define DXEN_DEFINES_SVH
`define DXEN_ADDR_W        12
`define DXEN_OFS_CTRL      12'h000
`define DXEN_OFS_STATUS    12'h004
`define DXEN_CTRL_CMD_BIT  0
`define DXEN_CTRL_RST_BIT  1
`define DXEN_CTRL_COMB_BIT 2
`define DXEN_CTRL_POVR_BIT 3
`define DXEN_CTRL_PLOW_BIT 4
`define DXEN_CTRL_IDX_LSB  8
`define DXEN_CTRL_IDX_MSB  10
`define DXEN_CTRL_SEL_BIT  11
`define DXEN_SYNC_STAGES   2
`endif

/* File: hw/dxen_pkg.sv */
// types shared by the drive enable gate
package dxen_pkg;
   // software settings of the gate
   typedef struct packed {
      logic       sel_en;     // general input supplies the command
      logic [2:0] sel_idx;    // which general input
      logic       pol_ovr;    // software overrides wiring polarity
      logic       pol_low;    // forced polarity: 1 = active low
      logic       comb_mode;  // combined enable mode
   } dxen_ctrl_s;
endpackage

/* File: hw/dxen_sync.sv */
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`include "dxen_defines.svh"
module dxen_sync #(
   parameter int WIDTH = 11
) (
   // clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_sys_rst,
   // levels
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;  // first stage, read only by the second

   // plain two-stage capture; bits are independent levels, so no bus skew concern
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_reg <= '0;
         o_sync   <= '0;
      end else begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end
endmodule

/* File: test/dxen_pins.sv */
// model of the enable wiring, the front panel switch and the general inputs
`timescale 1ns/1ns
module dxen_pins (
   // wanted states
   input  wire logic       i_energise,
   input  wire logic       i_switch_on,
   input  wire logic       i_ref_at_supply,
   input  wire logic [7:0] i_din_active,
   // pin levels
   output logic            o_hw_enable_pin,
   output logic            o_local_switch,
   output logic            o_input_common_reference,
   output logic [7:0]      o_general_input
);
   // the switched pin carries the enable whichever way the reference is wired
   assign o_hw_enable_pin = i_energise;
   assign o_local_switch = i_switch_on;
   assign o_input_common_reference = i_ref_at_supply;
   // reference at supply: an active input is pulled to ground
   assign o_general_input = i_ref_at_supply ? ~i_din_active : i_din_active;
endmodule

/* File: test/dxen_gate_tb.sv */
// self-checking testbench of the drive enable gate
`timescale 1ns/1ns
`include "dxen_defines.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin bad_count++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module dxen_gate_tb;
   logic        i_clk_sys = 1'b0;   // 25 MHz system clock
   logic        i_sys_rst = 1'b1;   // held for two cycles
   logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic        o_pready, o_pslverr, err, o_motion_permit, hw_pin, sw_pin, ref_pin;
   logic        hw_on = 1'b0, sw_on = 1'b0, ref_hi = 1'b0;
   logic [7:0]  din_act = 8'h00, din_pin, gin;
   int          bad_count = 0, num_checks = 0;
   always #20 i_clk_sys = ~i_clk_sys;
   dxen_pins pm (.i_energise(hw_on), .i_switch_on(sw_on), .i_ref_at_supply(ref_hi), .i_din_active(din_act),
      .o_hw_enable_pin(hw_pin), .o_local_switch(sw_pin), .o_input_common_reference(ref_pin),
      .o_general_input(din_pin));
   dxen_gate uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_hw_enable_pin(hw_pin), .i_local_switch(sw_pin),
      .i_input_common_reference(ref_pin), .i_general_input(din_pin), .o_motion_permit(o_motion_permit),
      .o_general_input_active(gin));
   // verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one apb transfer; pready is a register, so iff sees the value of the completing edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      @(posedge i_clk_sys iff o_pready === 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // let n edges pass, then look between edges where outputs are settled
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
   endtask
   // pins take three edges to reach the outputs
   task automatic pins(input logic h, input logic s);
      @(posedge i_clk_sys);
      hw_on <= h;
      sw_on <= s;
      settle(4);
   endtask
   // reset values and an unmapped address
   task automatic t_reset;
      `CHK("permit", 1'b0, o_motion_permit)
      apb(1'b0, `DXEN_OFS_CTRL, 32'h0);
      `CHK("ctrl", 32'h0, rd)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("err", 1'b1, err)
      `CHK("rdata", 32'h0, rd)
   endtask
   // enable by writing one, drop by switch, re-enable by reset command
   task automatic t_enable;
      pins(1'b1, 1'b1);
      `CHK("no cmd", 1'b0, o_motion_permit)
      apb(1'b1, `DXEN_OFS_CTRL, 32'h1);
      settle(1);
      `CHK("cmd", 1'b1, o_motion_permit)
      pins(1'b1, 1'b0);
      `CHK("sw off", 1'b0, o_motion_permit)
      pins(1'b1, 1'b1);
      `CHK("sw back", 1'b0, o_motion_permit)
      apb(1'b1, `DXEN_OFS_CTRL, 32'h2);
      settle(1);
      `CHK("rst cmd", 1'b1, o_motion_permit)
      apb(1'b1, `DXEN_OFS_STATUS, 32'h0);
      `CHK("ro err", 1'b0, err)
      apb(1'b0, `DXEN_OFS_STATUS, 32'h0);
      `CHK("status", 32'h0000000f, rd)
   endtask
   // wiring polarity, then software polarity which leaves the enable alone
   task automatic t_polarity;
      @(posedge i_clk_sys);
      din_act <= 8'h5a;
      ref_hi <= 1'b1;
      settle(4);
      `CHK("gin wired", 8'h5a, gin)
      `CHK("en kept", 1'b1, o_motion_permit)
      apb(1'b1, `DXEN_OFS_CTRL, 32'h8);
      settle(2);
      `CHK("gin high", 8'ha5, gin)
      `CHK("cmd clr", 1'b0, o_motion_permit)
      apb(1'b1, `DXEN_OFS_CTRL, 32'h18);
      settle(2);
      `CHK("gin low", 8'h5a, gin)
      apb(1'b0, `DXEN_OFS_STATUS, 32'h0);
      `CHK("en not inverted", 32'h00005a13, rd)
   endtask
   // general input five as command source, then combined mode
   task automatic t_source;
      apb(1'b1, `DXEN_OFS_CTRL, 32'hd00);
      @(posedge i_clk_sys);
      ref_hi <= 1'b0;
      din_act <= 8'h20;
      settle(4);
      `CHK("din cmd", 1'b1, o_motion_permit)
      @(posedge i_clk_sys);
      din_act <= 8'hdf;
      settle(4);
      `CHK("din off", 1'b0, o_motion_permit)
      apb(1'b1, `DXEN_OFS_CTRL, 32'h4);
      pins(1'b1, 1'b0);
      `CHK("comb sw", 1'b0, o_motion_permit)
      pins(1'b1, 1'b1);
      `CHK("comb sw on", 1'b1, o_motion_permit)
      pins(1'b0, 1'b1);
      `CHK("comb hw off", 1'b0, o_motion_permit)
      pins(1'b1, 1'b1);
      `CHK("comb hw on", 1'b1, o_motion_permit)
   endtask
   // watchdog, far beyond the hundred or so cycles the tests need
   initial begin
      #200000;
      bad_count++;
      results();
   end
   initial begin
      repeat (2) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      settle(0);
      t_reset();
      t_enable();
      t_polarity();
      t_source();
      results();
   end
endmodule
